// ### inc/alarm_cal_defs.svh
`ifndef ALARM_CAL_DEFS_SVH
`define ALARM_CAL_DEFS_SVH

// concentration and threshold width
`define CONC_W          16
// number of threshold alarms
`define NUM_ALARMS      2
// calibration run time in clock cycles (stand-in for the real cal sequence)
`define CAL_CYCLES      32'd1000
// range identification one-hot codes, relay 1..4
`define RANGE_LOW_OH    4'h1
`define RANGE_MED_OH    4'h2
`define RANGE_HIGH_OH   4'h4
`define RANGE_AIR_OH    4'h8
// range id dac codes, 8-bit full scale = 1 V
`define RANGE_LOW_DAC   8'h40
`define RANGE_MED_DAC   8'h80
`define RANGE_HIGH_DAC  8'hc0
`define RANGE_AIR_DAC   8'hff
// power button sequence for system alarm reset
`define SEQ_IDLE        2'h0
`define SEQ_OFF         2'h1
`define SEQ_ON          2'h2

`endif

// ### inc/alarm_cal_pkg.sv
package alarm_cal_pkg;
	typedef enum logic [1:0] {
		RANGE_LOW  = 2'h0,
		RANGE_MED  = 2'h1,
		RANGE_HIGH = 2'h2,
		RANGE_AIR  = 2'h3
	} range_e;

	typedef enum logic [2:0] {
		CAL_IDLE = 3'b001,
		CAL_ZERO = 3'b010,
		CAL_SPAN = 3'b100
	} cal_state_e;

	typedef enum logic [2:0] {
		CTL_WAIT_OPEN = 3'b001,
		CTL_REQ       = 3'b010,
		CTL_WAIT_DONE = 3'b100
	} ctl_state_e;
endpackage

// ### inc/remote_cal_if.sv
interface remote_cal_if;
	logic zero_req;
	logic span_req;
	logic cal_busy;
	logic zero_valve;
	logic span_valve;

	modport analyzer (
		input  zero_req,
		input  span_req,
		output cal_busy
	);

	modport controller (
		output zero_req,
		output span_req,
		output zero_valve,
		output span_valve,
		input  cal_busy
	);
endinterface

// ### hdl/alarm_cal_analyzer.sv
`include "alarm_cal_defs.svh"

module alarm_cal_analyzer
	import alarm_cal_pkg::*;
#(
	parameter int          CONC_W     = `CONC_W,
	parameter int          NUM_ALARMS = `NUM_ALARMS,
	parameter logic [31:0] CAL_CYCLES = `CAL_CYCLES
) (
	// clock and reset
	input  wire logic                  core_clk_i,
	input  wire logic                  rst_b_i,
	input  wire logic                  clk_en_i,
	// measurement and alarm configuration
	input  wire logic [CONC_W-1:0]     conc_i,
	input  wire logic [CONC_W-1:0]     thresh_i [NUM_ALARMS],
	input  wire logic [NUM_ALARMS-1:0] alarm_high_i,
	input  wire logic [NUM_ALARMS-1:0] alarm_failsafe_i,
	input  wire logic [NUM_ALARMS-1:0] alarm_latch_i,
	input  wire logic [NUM_ALARMS-1:0] alarm_defeat_i,
	// system alarm sources and front panel
	input  wire logic                  supply_bad_i,
	input  wire logic                  self_test_fail_i,
	input  wire logic                  power_btn_i,
	input  wire logic                  system_btn_i,
	input  wire logic                  other_btn_i,
	// range selection
	input  wire logic [1:0]            range_i,
	// remote calibration link
	remote_cal_if.analyzer             link,
	// outputs
	output logic [NUM_ALARMS-1:0]      alarm_relay_o,
	output logic [NUM_ALARMS-1:0]      alarm_active_o,
	output logic                       sys_relay_o,
	output logic                       sys_alarm_o,
	output logic                       cal_zero_o,
	output logic                       cal_span_o,
	output logic [3:0]                 range_relay_o,
	output logic [7:0]                 range_dac_o
);

	////////////////////////////////////////////////////////////////////////////
	// threshold alarms

	logic [NUM_ALARMS-1:0] cond;
	logic [NUM_ALARMS-1:0] alarm_next;

	always_comb begin
		for (int i = 0; i < NUM_ALARMS; i++) begin
			cond[i] = alarm_high_i[i] ? (conc_i > thresh_i[i]) : (conc_i < thresh_i[i]);
			if (alarm_defeat_i[i]) begin
				alarm_next[i] = 1'b0;
			end else if (alarm_latch_i[i]) begin
				alarm_next[i] = alarm_active_o[i] | cond[i];
			end else begin
				alarm_next[i] = cond[i];
			end
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			alarm_active_o <= '0;
		end else if (clk_en_i) begin
			alarm_active_o <= alarm_next;
		end
	end

	// relay drive registered from the next alarm value so it tracks without lag
	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			alarm_relay_o <= '0;
		end else if (clk_en_i) begin
			alarm_relay_o <= alarm_failsafe_i ^ alarm_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// system alarm: failsafe and latching, no configuration input exists

	logic [1:0] seq_reg;
	logic       sys_next;
	logic       pwr_prev_reg;
	logic       pwr_press;

	assign pwr_press = power_btn_i & ~pwr_prev_reg;

	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			pwr_prev_reg <= 1'b0;
		end else if (clk_en_i) begin
			pwr_prev_reg <= power_btn_i;
		end
	end

	// off press, on press, then any non-system button
	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			seq_reg <= `SEQ_IDLE;
		end else if (clk_en_i) begin
			if (!sys_alarm_o) begin
				seq_reg <= `SEQ_IDLE;
			end else begin
				case (seq_reg)
					`SEQ_IDLE: if (pwr_press) seq_reg <= `SEQ_OFF;
					`SEQ_OFF:  if (pwr_press) seq_reg <= `SEQ_ON;
					`SEQ_ON:   if (other_btn_i && !system_btn_i) seq_reg <= `SEQ_IDLE;
					default:   seq_reg <= `SEQ_IDLE;
				endcase
			end
		end
	end

	// set wins over the clearing sequence
	always_comb begin
		if (supply_bad_i || self_test_fail_i) begin
			sys_next = 1'b1;
		end else if (seq_reg == `SEQ_ON && other_btn_i && !system_btn_i) begin
			sys_next = 1'b0;
		end else begin
			sys_next = sys_alarm_o;
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			sys_alarm_o <= 1'b0;
			sys_relay_o <= 1'b1;
		end else if (clk_en_i) begin
			sys_alarm_o <= sys_next;
			sys_relay_o <= ~sys_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// remote calibration

	logic [1:0] zero_sync_reg;
	logic [1:0] span_sync_reg;
	logic       zero_req;
	logic       span_req;

	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			zero_sync_reg <= '0;
			span_sync_reg <= '0;
		end else if (clk_en_i) begin
			zero_sync_reg <= {zero_sync_reg[0], link.zero_req};
			span_sync_reg <= {span_sync_reg[0], link.span_req};
		end
	end

	assign zero_req = zero_sync_reg[1];
	assign span_req = span_sync_reg[1];

	cal_state_e  cal_reg;
	cal_state_e  cal_next;
	logic [31:0] cal_cnt_reg;
	logic        cal_done;
	logic        held;

	assign cal_done = (cal_cnt_reg == CAL_CYCLES - 32'd1);
	assign held     = (cal_reg == CAL_ZERO) ? zero_req : span_req;

	always_comb begin
		cal_next = cal_reg;
		case (cal_reg)
			CAL_IDLE: begin
				// polled only while idle; zero has priority if both appear
				if (zero_req) cal_next = CAL_ZERO;
				else if (span_req) cal_next = CAL_SPAN;
			end
			CAL_ZERO, CAL_SPAN: begin
				// other requests are not seen here and so are never stored
				if (cal_done && !held) cal_next = CAL_IDLE;
			end
			default: cal_next = CAL_IDLE;
		endcase
	end

	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cal_reg <= CAL_IDLE;
		end else if (clk_en_i) begin
			cal_reg <= cal_next;
		end
	end

	// a held request at completion restarts the same calibration
	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cal_cnt_reg <= '0;
		end else if (clk_en_i) begin
			if (cal_reg == CAL_IDLE || cal_done) begin
				cal_cnt_reg <= '0;
			end else begin
				cal_cnt_reg <= cal_cnt_reg + 32'd1;
			end
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			link.cal_busy <= 1'b0;
			cal_zero_o    <= 1'b0;
			cal_span_o    <= 1'b0;
		end else if (clk_en_i) begin
			// contact opens one cycle at completion so a rerun closes it again
			link.cal_busy <= (cal_next != CAL_IDLE) && !cal_done;
			cal_zero_o    <= (cal_next == CAL_ZERO) && !cal_done;
			cal_span_o    <= (cal_next == CAL_SPAN) && !cal_done;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// range identification

	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			range_relay_o <= `RANGE_LOW_OH;
			range_dac_o   <= `RANGE_LOW_DAC;
		end else if (clk_en_i) begin
			case (range_e'(range_i))
				RANGE_LOW: begin
					range_relay_o <= `RANGE_LOW_OH;
					range_dac_o   <= `RANGE_LOW_DAC;
				end
				RANGE_MED: begin
					range_relay_o <= `RANGE_MED_OH;
					range_dac_o   <= `RANGE_MED_DAC;
				end
				RANGE_HIGH: begin
					range_relay_o <= `RANGE_HIGH_OH;
					range_dac_o   <= `RANGE_HIGH_DAC;
				end
				default: begin
					range_relay_o <= `RANGE_AIR_OH;
					range_dac_o   <= `RANGE_AIR_DAC;
				end
			endcase
		end
	end

endmodule

// ### hdl/alarm_cal_controller.sv
`include "alarm_cal_defs.svh"

module alarm_cal_controller
	import alarm_cal_pkg::*;
(
	// clock and reset
	input  wire logic core_clk_i,
	input  wire logic rst_b_i,
	input  wire logic clk_en_i,
	// user side: one-cycle start pulses
	input  wire logic zero_start_i,
	input  wire logic span_start_i,
	// remote calibration link
	remote_cal_if.controller link,
	// user side status
	output logic      busy_o,
	output logic      done_o
);

	ctl_state_e state_reg;
	logic       is_zero_reg;
	logic       busy_prev_reg;

	// request raised only with contact open, dropped once it closes
	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state_reg     <= CTL_WAIT_OPEN;
			is_zero_reg   <= 1'b0;
			link.zero_req <= 1'b0;
			link.span_req <= 1'b0;
			busy_o        <= 1'b0;
			done_o        <= 1'b0;
			busy_prev_reg <= 1'b0;
		end else if (clk_en_i) begin
			busy_prev_reg <= link.cal_busy;
			done_o        <= 1'b0;
			case (state_reg)
				CTL_WAIT_OPEN: begin
					if (!link.cal_busy && (zero_start_i || span_start_i)) begin
						is_zero_reg   <= zero_start_i;
						link.zero_req <= zero_start_i;
						link.span_req <= ~zero_start_i;
						busy_o        <= 1'b1;
						state_reg     <= CTL_REQ;
					end
				end
				CTL_REQ: begin
					if (link.cal_busy) begin
						link.zero_req <= 1'b0;
						link.span_req <= 1'b0;
						state_reg     <= CTL_WAIT_DONE;
					end
				end
				CTL_WAIT_DONE: begin
					if (!link.cal_busy && busy_prev_reg) begin
						busy_o    <= 1'b0;
						done_o    <= 1'b1;
						state_reg <= CTL_WAIT_OPEN;
					end
				end
				default: state_reg <= CTL_WAIT_OPEN;
			endcase
		end
	end

	// valves follow the calibration that this controller started
	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			link.zero_valve <= 1'b0;
			link.span_valve <= 1'b0;
		end else if (clk_en_i) begin
			link.zero_valve <= busy_o && is_zero_reg && state_reg != CTL_WAIT_OPEN;
			link.span_valve <= busy_o && !is_zero_reg && state_reg != CTL_WAIT_OPEN;
		end
	end

endmodule

// ### testbench/alarm_cal_props.sv
module alarm_cal_props #(
	parameter int CAL_CYCLES = 8
) (
	// clock and reset
	input  wire logic core_clk_i,
	input  wire logic rst_b_i,
	// link signals
	input  wire logic zero_req,
	input  wire logic span_req,
	input  wire logic cal_busy,
	input  wire logic zero_valve,
	input  wire logic span_valve
);
	logic [15:0] run_reg;

	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (!rst_b_i);

	////////////////////////////////
	// length of the current busy run, held one cycle after the contact opens, then zero
	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i)
			run_reg <= 16'h0000;
		else if (cal_busy)
			run_reg <= run_reg + 16'h0001;
		else
			run_reg <= 16'h0000;
	end

	////////////////////////////////
	a_req_open: assert property ($rose(zero_req || span_req) |-> !cal_busy)
		else $error("request raised while busy");
	a_busy_ack: assert property ($rose(zero_req || span_req) |-> ##2 !cal_busy ##1 cal_busy)
		else $error("busy not closed three edges after request");
	a_req_held: assert property ($rose(zero_req) |-> zero_req [*4])
		else $error("zero request dropped before acknowledge");
	a_req_drop: assert property ($rose(cal_busy) |=> !zero_req && !span_req)
		else $error("request kept after acknowledge");
	a_zero_valve: assert property ($rose(zero_req) |=> zero_valve)
		else $error("zero valve not opened with request");
	a_span_valve: assert property ($rose(span_req) |=> span_valve)
		else $error("span valve not opened with request");
	a_valve_hold: assert property (cal_busy |-> zero_valve || span_valve)
		else $error("valve closed during calibration");
	a_valve_off: assert property ($fell(cal_busy) |-> ##[1:3] (!zero_valve && !span_valve))
		else $error("valve left open after calibration");
	a_busy_len: assert property ($fell(cal_busy) |-> run_reg == CAL_CYCLES)
		else $error("busy run length wrong");
endmodule

// ### testbench/tb_top.sv
`include "alarm_cal_defs.svh"

module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic               clk, rst_b, ce, zst, sst, sup, stf, pwr, sbt, obt, busy, done, srl, sal, cz, cs;
	logic [`CONC_W-1:0] conc;
	logic [`CONC_W-1:0] thr [2];
	logic [1:0]         hi, fs, lt, df, rng, rly, act;
	logic [3:0]         rr;
	logic [7:0]         rd;
	int                 bad_count, checked, cyc;

	remote_cal_if link ();
	remote_cal_if link_b ();

	// bench side of the second link keeps its valves in step with its requests
	assign link_b.zero_valve = link_b.zero_req;
	assign link_b.span_valve = link_b.span_req;

	alarm_cal_analyzer #(.CAL_CYCLES(32'd8)) alarm_cal_analyzer_inst (
		.core_clk_i(clk), .rst_b_i(rst_b), .clk_en_i(ce), .conc_i(conc), .thresh_i(thr),
		.alarm_high_i(hi), .alarm_failsafe_i(fs), .alarm_latch_i(lt), .alarm_defeat_i(df),
		.supply_bad_i(sup), .self_test_fail_i(stf), .power_btn_i(pwr), .system_btn_i(sbt),
		.other_btn_i(obt), .range_i(rng), .link(link), .alarm_relay_o(rly),
		.alarm_active_o(act), .sys_relay_o(srl), .sys_alarm_o(sal), .cal_zero_o(cz),
		.cal_span_o(cs), .range_relay_o(rr), .range_dac_o(rd));
	// second analyzer faces the bench, which breaks the request rules on purpose
	alarm_cal_analyzer #(.CAL_CYCLES(32'd8)) alarm_cal_analyzer_inst_b (
		.core_clk_i(clk), .rst_b_i(rst_b), .clk_en_i(ce), .conc_i(conc), .thresh_i(thr),
		.alarm_high_i(hi), .alarm_failsafe_i(fs), .alarm_latch_i(lt), .alarm_defeat_i(df),
		.supply_bad_i(sup), .self_test_fail_i(stf), .power_btn_i(pwr), .system_btn_i(sbt),
		.other_btn_i(obt), .range_i(rng), .link(link_b), .alarm_relay_o(),
		.alarm_active_o(), .sys_relay_o(), .sys_alarm_o(), .cal_zero_o(),
		.cal_span_o(), .range_relay_o(), .range_dac_o());
	alarm_cal_controller alarm_cal_controller_inst (
		.core_clk_i(clk), .rst_b_i(rst_b), .clk_en_i(ce), .zero_start_i(zst),
		.span_start_i(sst), .link(link), .busy_o(busy), .done_o(done));
	alarm_cal_props #(.CAL_CYCLES(8)) alarm_cal_props_inst (
		.core_clk_i(clk), .rst_b_i(rst_b), .zero_req(link.zero_req), .span_req(link.span_req),
		.cal_busy(link.cal_busy), .zero_valve(link.zero_valve), .span_valve(link.span_valve));

	////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	always @(posedge clk) begin
		cyc++;
		if (cyc == 2000) begin
			bad_count++;
			end_of_test();
		end
	end

	////////////////////////////////
	task step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task chk(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task end_of_test();
		$display("bad_count %0d checked %0d", bad_count, checked);
		if (bad_count == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// bounded wait for a busy level on either link
	task wt(input logic v, input logic b);
		int n;
		for (n = 0; n < 40; n++) begin
			if ((b ? link_b.cal_busy : link.cal_busy) === v) break;
			step(1);
		end
		chk(8'(n < 40), 8'h01);
	endtask

	task press();
		pwr = 1'b1;
		step(1);
		pwr = 1'b0;
		step(2);
	endtask

	////////////////////////////////
	task t_alarm();
		{thr[0], thr[1]} = {16'h0064, 16'h0064};
		{hi, fs, conc} = {2'h1, 2'h1, 16'h00c8};
		step(2);
		chk({4'h0, act, rly}, 8'h04);
		conc = 16'h0032;
		step(2);
		chk({4'h0, act, rly}, 8'h0b);
		{lt, conc} = {2'h3, 16'h00c8};
		step(2);
		conc = 16'h0064;
		step(2);
		chk({4'h0, act, rly}, 8'h0e);
		lt = 2'h0;
		step(2);
		chk({4'h0, act, rly}, 8'h01);
		{df, conc} = {2'h3, 16'h00c8};
		step(2);
		chk({4'h0, act, rly}, 8'h01);
		conc = 16'h0032;
		step(2);
		chk({4'h0, act, rly}, 8'h01);
		// clock enable low must freeze the alarm state
		{ce, df, conc} = {1'b0, 2'h0, 16'h00c8};
		step(2);
		chk({4'h0, act, rly}, 8'h01);
		ce = 1'b1;
		step(2);
		chk({4'h0, act, rly}, 8'h04);
	endtask

	task t_range();
		for (int r = 0; r < 4; r++) begin
			rng = 2'(r);
			step(2);
			chk({4'h0, rr}, 8'(1 << r));
			// air level saturates at full scale
			chk(rd, 8'(64 * r + 64 - (r == 3)));
		end
	endtask

	task t_sys();
		sup = 1'b1;
		step(1);
		sup = 1'b0;
		step(2);
		chk({6'h0, sal, srl}, 8'h02);
		obt = 1'b1;
		step(1);
		obt = 1'b0;
		step(2);
		chk({6'h0, sal, srl}, 8'h02);
		press();
		press();
		{sbt, obt} = 2'h3;
		step(1);
		{sbt, obt} = 2'h0;
		step(2);
		chk({6'h0, sal, srl}, 8'h02);
		rst_b = 1'b0;
		step(2);
		rst_b = 1'b1;
		step(1);
		chk({6'h0, sal, srl}, 8'h01);
		stf = 1'b1;
		step(1);
		stf = 1'b0;
		step(2);
		chk({6'h0, sal, srl}, 8'h02);
		press();
		press();
		obt = 1'b1;
		step(1);
		obt = 1'b0;
		step(2);
		chk({6'h0, sal, srl}, 8'h01);
	endtask

	task run(input logic z);
		int n;
		{zst, sst} = {z, !z};
		step(1);
		{zst, sst} = 2'h0;
		wt(1'b1, 1'b0);
		chk({6'h0, cz, cs}, {6'h0, z, !z});
		for (n = 0; n < 20 && link.cal_busy === 1'b1; n++)
			step(1);
		chk(8'(n), 8'h08);
		chk({6'h0, cz, cs}, 8'h00);
		for (n = 0; n < 10 && done !== 1'b1; n++)
			step(1);
		chk({6'h0, done, busy}, 8'h02);
	endtask

	task t_ignore();
		link_b.zero_req = 1'b1;
		step(2);
		chk({7'h0, link_b.cal_busy}, 8'h00);
		step(1);
		chk({7'h0, link_b.cal_busy}, 8'h01);
		{link_b.zero_req, link_b.span_req} = 2'h1;
		step(2);
		link_b.span_req = 1'b0;
		wt(1'b0, 1'b1);
		step(10);
		chk({7'h0, link_b.cal_busy}, 8'h00);
	endtask

	task t_repeat();
		link_b.zero_req = 1'b1;
		wt(1'b1, 1'b1);
		wt(1'b0, 1'b1);
		wt(1'b1, 1'b1);
		link_b.zero_req = 1'b0;
		wt(1'b0, 1'b1);
		step(10);
		chk({7'h0, link_b.cal_busy}, 8'h00);
	endtask

	////////////////////////////////
	initial begin
		{rst_b, zst, sst, sup, stf, pwr, sbt, obt} = 8'h00;
		ce = 1'b1;
		{conc, hi, fs, lt, df, rng} = '0;
		{thr[0], thr[1]} = '0;
		{link_b.zero_req, link_b.span_req} = 2'h0;
		step(8);
		rst_b = 1'b1;
		step(1);
		t_alarm();
		t_range();
		t_sys();
		run(1'b1);
		run(1'b0);
		t_ignore();
		t_repeat();
		end_of_test();
	end
endmodule
